// ==== src/lwc_core.sv ====
// lwc_core: executes compare, transfer, swap and add/sub word instructions.
// assumes one command at a time; loader writes are taken only while idle.
// Function
// - single compare is signed; contacts mean greater, equal, less in that order
// - single compare turns exactly one contact on, the other two off
// - compare with entry inactive leaves its three contacts unchanged
// - contacts stay latched until written again or a point or range clear resets them
// - zone compare writes three consecutive contacts from the named address
// - zone contacts mean below lower, within limits inclusive, above upper
// - program keeps lower at or below upper; otherwise all three contacts clear
// - transfer copies source as binary into destination, source untouched
// - bit operands span 16 or 32 bits; bit and word kinds mix
// - transfer with entry inactive leaves destination unchanged
// - block transfer copies count elements, both addresses stepping per element
// - fill transfer writes one source value into count destination elements
// - swap exchanges the two operands' contents
// - add sums two sources as signed integers into destination
// - subtract takes second source from first, signed, into destination
// - msb of arithmetic result is the sign, zero positive
// - wide operands: named word holds low half, next word high half
module lwc_core
    import lwc_pkg::*;
#(
    parameter int AW = 8  // address width of word and bit areas
) (
    input  wire logic          CLK_I,        // 20 MHz clock
    input  wire logic          RST_N_I,      // sync reset, active low
    input  wire logic          CMD_VALID_I,  // command offered
    input  wire logic [3:0]    CMD_OP_I,     // instruction code
    input  wire logic          CMD_WIDE_I,   // 32-bit form
    input  wire logic          CMD_ENTRY_I,  // entry condition
    input  wire logic [1:0]    CMD_KA_I,     // first source kind
    input  wire logic [AW-1:0] CMD_AA_I,     // first source address
    input  wire logic [31:0]   CMD_IMM_A_I,  // first source constant
    input  wire logic [1:0]    CMD_KB_I,     // second source kind
    input  wire logic [AW-1:0] CMD_AB_I,     // second source address
    input  wire logic [31:0]   CMD_IMM_B_I,  // second source constant
    input  wire logic [1:0]    CMD_KC_I,     // zone value kind
    input  wire logic [AW-1:0] CMD_AC_I,     // zone value address
    input  wire logic [31:0]   CMD_IMM_C_I,  // zone value constant
    input  wire logic [1:0]    CMD_KD_I,     // destination kind
    input  wire logic [AW-1:0] CMD_AD_I,     // destination address
    input  wire logic [AW-1:0] CMD_CNT_I,    // element or clear count
    input  wire logic          LD_WORD_WE_I, // loader word write
    input  wire logic          LD_BIT_WE_I,  // loader bit write
    input  wire logic [AW-1:0] LD_ADDR_I,    // loader address
    input  wire logic [15:0]   LD_DATA_I,    // loader data, bit uses lsb
    input  wire logic [AW-1:0] RD_ADDR_I,    // readback address
    output logic [15:0]        RD_WORD_O,    // word at readback address
    output logic               RD_BIT_O,     // contact at readback address
    output logic               BUSY_O,       // command in progress
    output logic               DONE_O        // one-cycle completion pulse
);
    localparam int NW = 1 << AW;

    lwc_calc_if calc ();

    lwc_state_type           state;
    logic                    busy;
    lwc_op_type              op;
    logic                    wide;
    logic                    entry;
    lwc_kind_type            ka, kb, kc, kd;
    logic [AW-1:0]           aa, ab, ac, ad, cnt, idx;
    logic [31:0]             imm_a, imm_b, imm_c;
    logic [15:0]             word_mem [NW];
    logic [NW-1:0]           bit_area;
    logic                    accept, multi, last, act;
    logic [AW-1:0]           cur_a, cur_d;
    logic [31:0]             val_a, val_b, res;
    logic [WR_PORTS-1:0]     ww_en;
    logic [AW-1:0]           ww_a [WR_PORTS];
    logic [15:0]             ww_d [WR_PORTS];
    logic [NW-1:0]           bw_mask, bw_data;
    logic [15:0]             src_word_now, dst_word_now;
    logic [2:0]              cont3;

    // ======================================================
    // operand helpers
    function automatic logic [31:0] fetch(input lwc_kind_type k, input logic [AW-1:0] a,
                                          input logic [31:0] imm, input logic w);
        logic [31:0] v;
        v = '0;
        unique case (k)
            KIND_WORD:  v = {word_mem[a + 1'b1], word_mem[a]};
            KIND_BIT: begin
                for (int i = 0; i < FULL_BITS; i++) begin
                    v[i] = bit_area[AW'(a + AW'(i))];
                end
            end
            default:    v = imm;
        endcase
        if (!w) begin
            v = {{HALF_BITS{v[HALF_BITS-1]}}, v[HALF_BITS-1:0]};
        end
        return v;
    endfunction

    function automatic logic [AW-1:0] step_of(input lwc_kind_type k, input logic w);
        if (k == KIND_BIT) begin
            return w ? AW'(SPAN_FULL) : AW'(SPAN_HALF);
        end
        return w ? AW'(2) : AW'(1);
    endfunction

    // ======================================================
    // command acceptance and sequencing
    assign accept = CMD_VALID_I && !busy;
    assign multi  = (op == OP_BLOCK) || (op == OP_FILL);
    assign last   = !multi || (cnt == '0) || (idx == AW'(cnt - 1'b1));
    assign act    = busy && entry && !(multi && cnt == '0);

    // command registers
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            op    <= OP_CMP;
            wide  <= 1'b0;
            entry <= 1'b0;
            ka    <= KIND_WORD;
            kb    <= KIND_WORD;
            kc    <= KIND_WORD;
            kd    <= KIND_WORD;
            aa    <= '0;
            ab    <= '0;
            ac    <= '0;
            ad    <= '0;
            cnt   <= '0;
            imm_a <= '0;
            imm_b <= '0;
            imm_c <= '0;
        end else if (accept) begin
            op    <= lwc_op_type'(CMD_OP_I);
            wide  <= CMD_WIDE_I;
            entry <= CMD_ENTRY_I;
            ka    <= lwc_kind_type'(CMD_KA_I);
            kb    <= lwc_kind_type'(CMD_KB_I);
            kc    <= lwc_kind_type'(CMD_KC_I);
            kd    <= lwc_kind_type'(CMD_KD_I);
            aa    <= CMD_AA_I;
            ab    <= CMD_AB_I;
            ac    <= CMD_AC_I;
            ad    <= CMD_AD_I;
            cnt   <= CMD_CNT_I;
            imm_a <= CMD_IMM_A_I;
            imm_b <= CMD_IMM_B_I;
            imm_c <= CMD_IMM_C_I;
        end
    end

    // state, element index and handshake flags
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            state <= ST_IDLE;
            busy  <= 1'b0;
            idx   <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    idx  <= '0;
                    if (accept) begin
                        state <= ST_RUN;
                        busy  <= 1'b1;
                    end
                end
                ST_RUN: begin
                    idx  <= idx + 1'b1;
                    if (last) begin
                        state <= ST_IDLE;
                        busy  <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ======================================================
    // operand fetch and compute
    assign cur_a = (op == OP_BLOCK) ? AW'(aa + AW'(idx * step_of(ka, wide))) : aa;
    assign cur_d = multi ? AW'(ad + AW'(idx * step_of(kd, wide))) : ad;
    // fetch sits in a process so that storage writes also re-run it
    always_comb begin
        val_a  = fetch(ka, cur_a, imm_a, wide);
        val_b  = fetch(kb, ab, imm_b, wide);
        calc.c = fetch(kc, ac, imm_c, wide);
    end

    assign calc.wide = wide;
    assign calc.a    = val_a;
    assign calc.b    = val_b;

    lwc_arith u_arith (
        .calc (calc)
    );

    lwc_cmp u_cmp (
        .calc (calc)
    );

    // value stored by transfers and arithmetic
    always_comb begin
        unique case (op)
            OP_ADD:  res = calc.sum;
            OP_SUB:  res = calc.diff;
            default: res = val_a;
        endcase
    end

    // ======================================================
    // write plan for this cycle
    always_comb begin
        ww_en   = '0;
        bw_mask = '0;
        bw_data = '0;
        for (int p = 0; p < WR_PORTS; p++) begin
            ww_a[p] = '0;
            ww_d[p] = '0;
        end
        if (act) begin
            unique case (op)
                OP_CMP, OP_ZONE: begin
                    for (int i = 0; i < CONTACTS; i++) begin
                        bw_mask[AW'(ad + AW'(i))] = 1'b1;
                        bw_data[AW'(ad + AW'(i))] = (op == OP_CMP) ? calc.single[i] : calc.zone[i];
                    end
                end
                OP_SWAP: begin
                    ww_en[0] = 1'b1;
                    ww_a[0]  = ad;
                    ww_d[0]  = val_a[15:0];
                    ww_en[1] = 1'b1;
                    ww_a[1]  = aa;
                    ww_d[1]  = word_mem[ad];
                    ww_en[2] = wide;
                    ww_a[2]  = AW'(ad + 1'b1);
                    ww_d[2]  = val_a[31:16];
                    ww_en[3] = wide;
                    ww_a[3]  = AW'(aa + 1'b1);
                    ww_d[3]  = word_mem[AW'(ad + 1'b1)];
                end
                OP_CLR: begin
                    for (int k = 0; k < NW; k++) begin
                        if (AW'(AW'(k) - ad) < cnt) begin
                            bw_mask[k] = 1'b1;
                        end
                    end
                end
                default: begin
                    if (kd == KIND_BIT) begin
                        for (int i = 0; i < FULL_BITS; i++) begin
                            if (i < HALF_BITS || wide) begin
                                bw_mask[AW'(cur_d + AW'(i))] = 1'b1;
                                bw_data[AW'(cur_d + AW'(i))] = res[i];
                            end
                        end
                    end else begin
                        ww_en[0] = 1'b1;
                        ww_a[0]  = cur_d;
                        ww_d[0]  = res[15:0];
                        ww_en[1] = wide;
                        ww_a[1]  = AW'(cur_d + 1'b1);
                        ww_d[1]  = res[31:16];
                    end
                end
            endcase
        end
    end

    // ======================================================
    // storage: word area, no reset; contacts reset clear
    always_ff @(posedge CLK_I) begin
        if (LD_WORD_WE_I && !busy) begin
            word_mem[LD_ADDR_I] <= LD_DATA_I;
        end
        for (int p = 0; p < WR_PORTS; p++) begin
            if (ww_en[p]) begin
                word_mem[ww_a[p]] <= ww_d[p];
            end
        end
    end

    // contacts latch until written again or cleared
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            bit_area <= '0;
        end else begin
            for (int k = 0; k < NW; k++) begin
                if (bw_mask[k]) begin
                    bit_area[k] <= bw_data[k];
                end else if (LD_BIT_WE_I && !busy && LD_ADDR_I == AW'(k)) begin
                    bit_area[k] <= LD_DATA_I[0];
                end
            end
        end
    end

    // ======================================================
    // outputs
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            RD_WORD_O <= 16'h0000;
            RD_BIT_O  <= 1'b0;
            BUSY_O    <= 1'b0;
            DONE_O    <= 1'b0;
        end else begin
            RD_WORD_O <= word_mem[RD_ADDR_I];
            RD_BIT_O  <= bit_area[RD_ADDR_I];
            BUSY_O    <= accept || (busy && !last);
            DONE_O    <= busy && last;
        end
    end

    // ======================================================
    // checks
    assign src_word_now = word_mem[aa];
    assign dst_word_now = word_mem[ad];
    assign cont3 = {bit_area[AW'(ad + 2'd2)], bit_area[AW'(ad + 1'b1)], bit_area[ad]};

    one_hot_cmp_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (busy && entry && op == OP_CMP) |=> $onehot(cont3))
        else $error("single compare did not leave exactly one contact on");

    greater_first_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (busy && entry && op == OP_CMP && $signed(val_a) > $signed(val_b)) |=> cont3 == RES_FIRST)
        else $error("greater compare did not set first contact");

    hold_when_off_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (busy && !entry) |=> $stable(bit_area) && dst_word_now == $past(dst_word_now))
        else $error("inactive entry changed a destination");

    zone_bad_clear_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (busy && entry && op == OP_ZONE && $signed(calc.a) > $signed(calc.b)) |=> cont3 == RES_NONE)
        else $error("zone compare with crossed limits left a contact on");

    zone_within_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (busy && entry && op == OP_ZONE && $signed(calc.a) <= $signed(calc.c)
         && $signed(calc.c) <= $signed(calc.b)) |=> cont3 == RES_SECOND)
        else $error("zone compare within limits did not set middle contact");

    swap_exchange_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (busy && entry && op == OP_SWAP && !wide && aa != ad)
        |=> dst_word_now == $past(src_word_now) && src_word_now == $past(dst_word_now))
        else $error("swap did not exchange operands");

    add_store_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (busy && entry && op == OP_ADD && kd == KIND_WORD && !wide)
        |=> dst_word_now == $past(calc.sum[15:0]))
        else $error("add result not stored");

    src_intact_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (busy && entry && op == OP_MOV && kd == KIND_WORD && !wide && aa != ad)
        |=> $stable(src_word_now))
        else $error("transfer modified its source");

    done_follows_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (busy && last) |=> DONE_O && !BUSY_O ##1 !DONE_O)
        else $error("completion pulse wrong");
endmodule

// ==== src/lwc_pkg.sv ====
// lwc_pkg: shared codes, widths and contact positions for the ladder word unit.
// assumes a single clock domain and a one-element-per-cycle sequencer.
package lwc_pkg;
    // ======================================================
    // instruction codes
    typedef enum logic [3:0] {
        OP_CMP   = 4'h0,  // single_compare
        OP_ZONE  = 4'h1,  // zone_compare
        OP_MOV   = 4'h2,  // word_transfer
        OP_BLOCK = 4'h3,  // block_transfer
        OP_FILL  = 4'h4,  // fill_transfer
        OP_SWAP  = 4'h5,  // operand_swap
        OP_ADD   = 4'h6,
        OP_SUB   = 4'h7,
        OP_CLR   = 4'h8   // range_clear, count 1 acts as a single-point reset
    } lwc_op_type;

    // operand kinds
    typedef enum logic [1:0] {
        KIND_WORD  = 2'h0,
        KIND_BIT   = 2'h1,
        KIND_CONST = 2'h2
    } lwc_kind_type;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } lwc_state_type;

    // ======================================================
    // widths and contact layout
    localparam int           HALF_BITS  = 16;
    localparam int           FULL_BITS  = 32;
    localparam int           CONTACTS   = 3;
    localparam int           WR_PORTS   = 4;
    localparam logic [5:0]   SPAN_HALF  = 6'h10;
    localparam logic [5:0]   SPAN_FULL  = 6'h20;
    localparam logic [2:0]   RES_FIRST  = 3'h1;
    localparam logic [2:0]   RES_SECOND = 3'h2;
    localparam logic [2:0]   RES_THIRD  = 3'h4;
    localparam logic [2:0]   RES_NONE   = 3'h0;
endpackage

// ==== src/lwc_calc_if.sv ====
// lwc_calc_if: operands and results between the core and its compute units.
// assumes operands arrive already sign extended to 32 bits.
interface lwc_calc_if;
    logic        wide;
    logic [31:0] a;     // first source / lower limit
    logic [31:0] b;     // second source / upper limit
    logic [31:0] c;     // zone tested value
    logic [31:0] sum;
    logic [31:0] diff;
    logic [2:0]  single; // {lt, eq, gt}
    logic [2:0]  zone;   // {above, within, below}, all zero on bad limits

    modport core  (output wide, a, b, c, input sum, diff, single, zone);
    modport arith (input wide, a, b, output sum, diff);
    modport cmp   (input a, b, c, output single, zone);
endinterface

// ==== src/lwc_arith.sv ====
// lwc_arith: signed add and subtract for the word unit.
// assumes the caller keeps only the low half of results in the narrow form.
module lwc_arith
    import lwc_pkg::*;
(
    lwc_calc_if.arith calc  // operands in, results out
);
    logic [31:0] raw_sum;   // full-width sum before narrowing
    logic [31:0] raw_diff;  // full-width difference before narrowing

    // ======================================================
    // two's complement: msb is the sign, wrap drops the carry silently
    always_comb begin
        raw_sum  = calc.a + calc.b;
        raw_diff = calc.a - calc.b;
        if (calc.wide) begin
            calc.sum  = raw_sum;
            calc.diff = raw_diff;
        end else begin
            // narrow form: keep the low half and re-extend its sign, no flag
            calc.sum  = {{HALF_BITS{raw_sum[HALF_BITS-1]}}, raw_sum[HALF_BITS-1:0]};
            calc.diff = {{HALF_BITS{raw_diff[HALF_BITS-1]}}, raw_diff[HALF_BITS-1:0]};
        end
    end
endmodule

// ==== src/lwc_cmp.sv ====
// lwc_cmp: signed single and zone comparison for the word unit.
// assumes narrow operands are sign extended before they arrive.
module lwc_cmp
    import lwc_pkg::*;
(
    lwc_calc_if.cmp calc  // operands in, contact patterns out
);
    logic signed [31:0] sa;
    logic signed [31:0] sb;
    logic signed [31:0] sc;

    // ======================================================
    // contact patterns, one bit per destination contact
    always_comb begin
        sa = $signed(calc.a);
        sb = $signed(calc.b);
        sc = $signed(calc.c);
        if (sa > sb) begin
            calc.single = RES_FIRST;
        end else if (sa == sb) begin
            calc.single = RES_SECOND;
        end else begin
            calc.single = RES_THIRD;
        end
        if (sa > sb) begin
            calc.zone = RES_NONE;
        end else if (sc < sa) begin
            calc.zone = RES_FIRST;
        end else if (sc > sb) begin
            calc.zone = RES_THIRD;
        end else begin
            calc.zone = RES_SECOND;
        end
    end
endmodule

// ==== tb/lwc_core_tb_top.sv ====
// lwc_core_tb_top: self-checking bench for the ladder word unit.
// assumes lwc_pkg and lwc_core are compiled first; the bench drives every port itself.
module lwc_core_tb_top;
    import lwc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // ======================================================
    // signals
    logic        CLK_I = 0, RST_N_I = 0, CMD_VALID_I = 0, CMD_WIDE_I = 0, CMD_ENTRY_I = 0;
    logic [3:0]  CMD_OP_I = 4'h0;
    logic [1:0]  CMD_KA_I = 2'h0, CMD_KB_I = 2'h0, CMD_KD_I = 2'h0;
    logic [7:0]  CMD_AA_I = 8'h00, CMD_AB_I = 8'h00, CMD_AD_I = 8'h00, CMD_CNT_I = 8'h00;
    logic [31:0] CMD_IMM_A_I = 32'h0000_0000, CMD_IMM_B_I = 32'h0000_0000, CMD_IMM_C_I = 32'h0000_0000;
    logic        LD_WORD_WE_I = 0, LD_BIT_WE_I = 0;
    logic [7:0]  LD_ADDR_I = 8'h00, RD_ADDR_I = 8'h00;
    logic [15:0] LD_DATA_I = 16'h0000, RD_WORD_O;
    logic        RD_BIT_O, BUSY_O, DONE_O;
    int          num_errors = 0, checked = 0;
    // ======================================================
    // clock and design under test
    always #25 CLK_I = ~CLK_I;  // 20 MHz
    lwc_core #(.AW(8)) lwc_core_i (
        .CLK_I(CLK_I), .RST_N_I(RST_N_I), .CMD_VALID_I(CMD_VALID_I), .CMD_OP_I(CMD_OP_I),
        .CMD_WIDE_I(CMD_WIDE_I), .CMD_ENTRY_I(CMD_ENTRY_I), .CMD_KA_I(CMD_KA_I), .CMD_AA_I(CMD_AA_I),
        .CMD_IMM_A_I(CMD_IMM_A_I), .CMD_KB_I(CMD_KB_I), .CMD_AB_I(CMD_AB_I), .CMD_IMM_B_I(CMD_IMM_B_I),
        .CMD_KC_I(KIND_CONST), .CMD_AC_I(8'h00), .CMD_IMM_C_I(CMD_IMM_C_I), .CMD_KD_I(CMD_KD_I),
        .CMD_AD_I(CMD_AD_I), .CMD_CNT_I(CMD_CNT_I), .LD_WORD_WE_I(LD_WORD_WE_I), .LD_BIT_WE_I(LD_BIT_WE_I),
        .LD_ADDR_I(LD_ADDR_I), .LD_DATA_I(LD_DATA_I), .RD_ADDR_I(RD_ADDR_I), .RD_WORD_O(RD_WORD_O),
        .RD_BIT_O(RD_BIT_O), .BUSY_O(BUSY_O), .DONE_O(DONE_O));
    // ======================================================
    // helpers
    task automatic summarize();
        $display("errors %0d checked %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // word area write through the loader, one cycle strobe
    task automatic load(input logic [7:0] a, input logic [15:0] d);
        @(posedge CLK_I);
        LD_WORD_WE_I <= 1'b1;
        LD_ADDR_I    <= a;
        LD_DATA_I    <= d;
        @(posedge CLK_I);
        LD_WORD_WE_I <= 1'b0;
    endtask
    // compare one handshake flag at a settled point
    task automatic chkf(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t flag got %b exp %b", $time, got, exp);
        end
    endtask
    // issue one command and wait for its completion pulse
    task automatic cmd(input logic [3:0] op, input logic [7:0] ad, input logic [31:0] ia, ib,
                       input logic [31:0] ic = 32'h0000_0000, input logic w = 0, input logic e = 1,
                       input logic [1:0] ka = KIND_CONST, input logic [7:0] aa = 8'h00,
                       input logic [1:0] kd = KIND_WORD, input logic [7:0] n = 8'h01,
                       input logic [1:0] kb = KIND_CONST);
        int i;
        @(posedge CLK_I);
        CMD_VALID_I <= 1'b1;  CMD_OP_I <= op;  CMD_AD_I <= ad;  CMD_IMM_A_I <= ia;
        CMD_IMM_B_I <= ib;  CMD_IMM_C_I <= ic;  CMD_WIDE_I <= w;  CMD_ENTRY_I <= e;
        CMD_KA_I <= ka;  CMD_AA_I <= aa;  CMD_KD_I <= kd;  CMD_CNT_I <= n;  CMD_KB_I <= kb;
        @(posedge CLK_I);
        CMD_VALID_I <= 1'b0;
        @(negedge CLK_I);
        chkf(BUSY_O, 1'b1);
        for (i = 0; i < 300 && DONE_O !== 1'b1; i++) @(negedge CLK_I);
        if (DONE_O !== 1'b1) begin
            num_errors++;
            $display("[FAIL] %0t no completion for op %h", $time, op);
        end
        chkf(BUSY_O, 1'b0);
        @(negedge CLK_I);
        chkf(DONE_O, 1'b0);
    endtask
    // compare a word read back from the word area
    task automatic rdw(input logic [7:0] a, input logic [15:0] exp);
        @(posedge CLK_I);
        RD_ADDR_I <= a;
        @(posedge CLK_I);
        @(negedge CLK_I);
        checked++;
        if (RD_WORD_O !== exp) begin
            num_errors++;
            $display("[FAIL] %0t word %h got %h exp %h", $time, a, RD_WORD_O, exp);
        end
    endtask
    // compare one contact read back from the bit area
    task automatic rdb(input logic [7:0] a, input logic exp);
        @(posedge CLK_I);
        RD_ADDR_I <= a;
        @(posedge CLK_I);
        @(negedge CLK_I);
        checked++;
        if (RD_BIT_O !== exp) begin
            num_errors++;
            $display("[FAIL] %0t contact %h got %b exp %b", $time, a, RD_BIT_O, exp);
        end
    endtask
    // ======================================================
    // scenarios
    task automatic t_compare();
        logic [31:0] ca[3] = '{32'hFFFF_FFFF, 32'h0000_0005, 32'h0000_0001};
        logic [31:0] cb[3] = '{32'h0000_0001, 32'h0000_0005, 32'hFFFF_FFFF};
        logic [2:0]  ce[3] = '{3'b100, 3'b010, 3'b001};
        for (int i = 0; i < 3; i++) begin
            cmd(OP_CMP, 8'h10, ca[i], cb[i]);
            for (int k = 0; k < 3; k++) rdb(8'h10 + 8'(k), ce[i][k]);
        end
        // entry inactive: contacts keep greater-than state
        cmd(OP_CMP, 8'h10, ca[0], cb[0], 32'h0000_0000, 1'b0, 1'b0);
        for (int k = 0; k < 3; k++) rdb(8'h10 + 8'(k), ce[2][k]);
        cmd(OP_CLR, 8'h10, 32'h0000_0000, 32'h0000_0000);
        rdb(8'h10, 1'b0);
    endtask
    task automatic t_zone();
        logic [31:0] zv[4] = '{32'h0000_0005, 32'h0000_000A, 32'h0000_0014, 32'h0000_0015};
        logic [2:0]  ze[4] = '{3'b001, 3'b010, 3'b010, 3'b100};
        for (int i = 0; i < 4; i++) begin
            cmd(OP_ZONE, 8'h20, 32'h0000_000A, 32'h0000_0014, zv[i]);
            for (int k = 0; k < 3; k++) rdb(8'h20 + 8'(k), ze[i][k]);
        end
        // lower above upper clears all three
        cmd(OP_ZONE, 8'h20, 32'h0000_0014, 32'h0000_000A, 32'h0000_0015);
        for (int k = 0; k < 3; k++) rdb(8'h20 + 8'(k), 1'b0);
        cmd(OP_ZONE, 8'h20, 32'h0000_000A, 32'h0000_0014, 32'h0000_0005);
        cmd(OP_CLR, 8'h20, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 0, 1, KIND_CONST, 8'h00,
            KIND_WORD, 8'h03);
        rdb(8'h20, 1'b0);
    endtask
    task automatic t_move();
        load(8'h40, 16'hA5C3);
        cmd(OP_MOV, 8'h41, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 0, 1, KIND_WORD, 8'h40);
        rdw(8'h41, 16'hA5C3);
        rdw(8'h40, 16'hA5C3);
        cmd(OP_MOV, 8'h41, 32'h0000_1234, 32'h0000_0000, 32'h0000_0000, 0, 0);
        rdw(8'h41, 16'hA5C3);
        cmd(OP_MOV, 8'h80, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 0, 1, KIND_WORD, 8'h40, KIND_BIT);
        rdb(8'h80, 1'b1);
        rdb(8'h82, 1'b0);
        rdb(8'h8F, 1'b1);
        cmd(OP_MOV, 8'h4A, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 0, 1, KIND_BIT, 8'h80);
        rdw(8'h4A, 16'hA5C3);
        cmd(OP_MOV, 8'h42, 32'h1234_5678, 32'h0000_0000, 32'h0000_0000, 1);
        rdw(8'h42, 16'h5678);
        rdw(8'h43, 16'h1234);
    endtask
    task automatic t_block();
        for (int i = 0; i < 3; i++) load(8'h50 + 8'(i), 16'(i + 1));
        load(8'h63, 16'h0000);
        load(8'h73, 16'h0000);
        cmd(OP_BLOCK, 8'h60, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 0, 1, KIND_WORD, 8'h50,
            KIND_WORD, 8'h03);
        cmd(OP_FILL, 8'h70, 32'h0000_0007, 32'h0000_0000, 32'h0000_0000, 0, 1, KIND_CONST, 8'h00,
            KIND_WORD, 8'h03);
        for (int i = 0; i < 3; i++) rdw(8'h60 + 8'(i), 16'(i + 1));
        for (int i = 0; i < 3; i++) rdw(8'h70 + 8'(i), 16'h0007);
        rdw(8'h63, 16'h0000);
        rdw(8'h73, 16'h0000);
    endtask
    task automatic t_swap_arith();
        load(8'h44, 16'h1111);
        load(8'h45, 16'h2222);
        cmd(OP_SWAP, 8'h45, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 0, 1, KIND_WORD, 8'h44);
        rdw(8'h44, 16'h2222);
        rdw(8'h45, 16'h1111);
        cmd(OP_ADD, 8'h48, 32'h0000_7FFF, 32'h0000_0001);
        rdw(8'h48, 16'h8000);
        cmd(OP_SUB, 8'h48, 32'h0000_0001, 32'h0000_0002);
        rdw(8'h48, 16'hFFFF);
        cmd(OP_ADD, 8'h46, 32'h0000_FFFF, 32'h0000_0001, 32'h0000_0000, 1);
        rdw(8'h46, 16'h0000);
        rdw(8'h47, 16'h0001);
        cmd(OP_SUB, 8'h46, 32'h0000_0000, 32'h0000_0001, 32'h0000_0000, 1);
        rdw(8'h47, 16'hFFFF);
    endtask
    // ======================================================
    // main sequence and watchdog
    initial begin
        repeat (20) @(posedge CLK_I);
        RST_N_I <= 1'b1;
        rdb(8'h12, 1'b0);
        t_compare();
        t_zone();
        t_move();
        t_block();
        t_swap_arith();
        summarize();
    end
    initial begin
        repeat (20000) @(posedge CLK_I);
        num_errors++;
        summarize();
    end
endmodule
